// ---- logic/spse_exec.sv ----
// Bus sequencer for sixteen-bit register stores and accumulator subtract
`timescale 1ns/1ps
`default_nettype none
module spse_exec
    import spse_pkg::*;
#(
    parameter logic [15:0] RESET_PC = spse_pkg::PC_RESET
)
(
    input  wire logic              core_clk_in,
    input  wire logic              reset_in,
    input  wire logic [7:0]        rdata_in,
    input  wire logic              load_en_in,
    input  wire spse_pkg::spse_tgt_t load_sel_in,
    input  wire logic [15:0]       load_val_in,
    output logic [15:0]            addr_out,
    output logic [7:0]             wdata_out,
    output logic                   rw_out,
    output logic                   opfetch_out,
    output logic [7:0]             acc_a_out,
    output logic [7:0]             acc_b_out,
    output logic [15:0]            sp_out,
    output logic [15:0]            ix_out,
    output logic [15:0]            iy_out,
    output logic [7:0]             flags_out
);
    import spse_pkg::*;

    // ********************************
    // State
    // ********************************
    typedef struct packed {
        spse_state_t st;
        spse_pfx_t   pfx;
        spse_tgt_t   tgt;
        spse_mode_t  mode;
        logic [15:0] pc;
        logic [15:0] ea;
        logic [15:0] addr;
        logic [7:0]  wdata;
        logic        rw;
        logic        opfetch;
        logic [7:0]  acc_a;
        logic [7:0]  acc_b;
        logic [15:0] sp;
        logic [15:0] ix;
        logic [15:0] iy;
        logic [7:0]  flags;
    } spse_regs_t;

    localparam spse_regs_t RESET_STATE = '{st: ST_FETCH, pfx: PFX_NONE, tgt: TGT_SP, mode: MODE_IMM,
                                           pc: RESET_PC, ea: REG_RESET, addr: RESET_PC, wdata: 8'h00,
                                           rw: 1'b1, opfetch: 1'b1, acc_a: 8'h00, acc_b: 8'h00,
                                           sp: REG_RESET, ix: REG_RESET, iy: REG_RESET, flags: FLAG_RESET};

    spse_regs_t  s_ff;
    spse_regs_t  nxt_s;
    spse_dec_t   dec;
    logic [15:0] store_val;
    logic [15:0] pc_inc;
    logic [15:0] ea_ind;
    logic        is_store;

    spse_alu_if alu_bus ();

    spse_sub_alu u_alu
    (
        .alu (alu_bus.calc)
    );

    // ********************************
    // Decode
    // ********************************
    // Unknown codes decode as invalid and fall through as a one-cycle no-op
    function automatic spse_dec_t decode(input spse_pfx_t pfx, input logic [7:0] op);
        spse_dec_t d;
        d = '{valid: 1'b1, tgt: TGT_SP, mode: MODE_IMM};
        case (pfx)
            PFX_NONE:
            begin
                case (op)
                    OP_SP_DIR:    d = '{1'b1, TGT_SP, MODE_DIR};
                    OP_SP_EXT:    d = '{1'b1, TGT_SP, MODE_EXT};
                    OP_SP_IND:    d = '{1'b1, TGT_SP, MODE_INDX};
                    OP_XY_DIR:    d = '{1'b1, TGT_X, MODE_DIR};
                    OP_XY_EXT:    d = '{1'b1, TGT_X, MODE_EXT};
                    OP_XY_IND:    d = '{1'b1, TGT_X, MODE_INDX};
                    OP_SUB_A_IMM: d = '{1'b1, TGT_A, MODE_IMM};
                    OP_SUB_A_DIR: d = '{1'b1, TGT_A, MODE_DIR};
                    OP_SUB_A_EXT: d = '{1'b1, TGT_A, MODE_EXT};
                    OP_SUB_A_IND: d = '{1'b1, TGT_A, MODE_INDX};
                    OP_SUB_B_IMM: d = '{1'b1, TGT_B, MODE_IMM};
                    OP_SUB_B_DIR: d = '{1'b1, TGT_B, MODE_DIR};
                    OP_SUB_B_EXT: d = '{1'b1, TGT_B, MODE_EXT};
                    OP_SUB_B_IND: d = '{1'b1, TGT_B, MODE_INDX};
                    default:      d.valid = 1'b0;
                endcase
            end
            PFX_18:
            begin
                case (op)
                    OP_SP_IND:   d = '{1'b1, TGT_SP, MODE_INDY};
                    OP_XY_DIR:   d = '{1'b1, TGT_Y, MODE_DIR};
                    OP_XY_EXT:   d = '{1'b1, TGT_Y, MODE_EXT};
                    OP_XY_IND:   d = '{1'b1, TGT_Y, MODE_INDY};
                    OP_SUB_A_IND: d = '{1'b1, TGT_A, MODE_INDY};
                    OP_SUB_B_IND: d = '{1'b1, TGT_B, MODE_INDY};
                    default:     d.valid = 1'b0;
                endcase
            end
            PFX_1A:
            begin
                if (op == OP_XY_IND)
                    d = '{1'b1, TGT_Y, MODE_INDX};
                else
                    d.valid = 1'b0;
            end
            PFX_CD:
            begin
                if (op == OP_XY_IND)
                    d = '{1'b1, TGT_X, MODE_INDY};
                else
                    d.valid = 1'b0;
            end
            default: d.valid = 1'b0;
        endcase
        return d;
    endfunction

    // ********************************
    // Operand selection
    // ********************************
    // Store source and indexed address from the latched instruction
    always_comb
    begin
        case (s_ff.tgt)
            TGT_X:   store_val = s_ff.ix;
            TGT_Y:   store_val = s_ff.iy;
            default: store_val = s_ff.sp;
        endcase
        pc_inc   = s_ff.pc + 16'h0001;
        is_store = (s_ff.tgt == TGT_SP) || (s_ff.tgt == TGT_X) || (s_ff.tgt == TGT_Y);
        if (s_ff.mode == MODE_INDY)
            ea_ind = s_ff.iy + {8'h00, rdata_in};
        else
            ea_ind = s_ff.ix + {8'h00, rdata_in};
        dec = decode(s_ff.pfx, rdata_in);
        alu_bus.acc  = (s_ff.tgt == TGT_B) ? s_ff.acc_b : s_ff.acc_a;
        alu_bus.opnd = rdata_in;
    end

    // ********************************
    // Sequencer
    // ********************************
    // Each clock is one bus cycle; the next cycle's address and direction are chosen here
    always_comb
    begin
        nxt_s         = s_ff;
        nxt_s.rw      = 1'b1;
        nxt_s.opfetch = 1'b0;
        // Debug loads yield to instruction results written below
        if (load_en_in)
        begin
            case (load_sel_in)
                TGT_SP:  nxt_s.sp = load_val_in;
                TGT_X:   nxt_s.ix = load_val_in;
                TGT_Y:   nxt_s.iy = load_val_in;
                TGT_A:   nxt_s.acc_a = load_val_in[7:0];
                default: nxt_s.acc_b = load_val_in[7:0];
            endcase
        end
        case (s_ff.st)
            ST_FETCH:
            begin
                nxt_s.pc   = pc_inc;
                nxt_s.addr = pc_inc;
                if (s_ff.pfx == PFX_NONE && (rdata_in == PRE_18 || rdata_in == PRE_1A || rdata_in == PRE_CD))
                begin
                    // Prebyte costs one extra fetch cycle
                    nxt_s.pfx     = (rdata_in == PRE_18) ? PFX_18 : ((rdata_in == PRE_1A) ? PFX_1A : PFX_CD);
                    nxt_s.opfetch = 1'b1;
                end
                else
                begin
                    nxt_s.pfx  = PFX_NONE;
                    nxt_s.tgt  = dec.tgt;
                    nxt_s.mode = dec.mode;
                    nxt_s.st   = dec.valid ? ST_OPER1 : ST_FETCH;
                    nxt_s.opfetch = !dec.valid;
                end
            end
            ST_OPER1:
            begin
                nxt_s.pc = pc_inc;
                case (s_ff.mode)
                    MODE_DIR:
                    begin
                        nxt_s.ea   = {DIRECT_PAGE, rdata_in};
                        nxt_s.addr = {DIRECT_PAGE, rdata_in};
                        nxt_s.st   = is_store ? ST_WR_HI : ST_RD;
                        nxt_s.rw   = !is_store;
                        nxt_s.wdata = store_val[15:8];
                    end
                    MODE_EXT:
                    begin
                        nxt_s.ea[15:8] = rdata_in;
                        nxt_s.addr     = pc_inc;
                        nxt_s.st       = ST_OPER2;
                    end
                    MODE_INDX, MODE_INDY:
                    begin
                        nxt_s.ea   = ea_ind;
                        nxt_s.addr = IDLE_ADDR;
                        nxt_s.st   = ST_IDLE;
                    end
                    default:
                    begin
                        // Immediate subtract completes on the operand fetch
                        if (s_ff.tgt == TGT_B)
                            nxt_s.acc_b = alu_bus.diff;
                        else
                            nxt_s.acc_a = alu_bus.diff;
                        nxt_s.flags[FLAG_N] = alu_bus.flag_n;
                        nxt_s.flags[FLAG_Z] = alu_bus.flag_z;
                        nxt_s.flags[FLAG_V] = alu_bus.flag_v;
                        nxt_s.flags[FLAG_C] = alu_bus.flag_c;
                        nxt_s.addr    = pc_inc;
                        nxt_s.opfetch = 1'b1;
                        nxt_s.st      = ST_FETCH;
                    end
                endcase
            end
            ST_OPER2, ST_IDLE:
            begin
                if (s_ff.st == ST_OPER2)
                begin
                    nxt_s.pc      = pc_inc;
                    nxt_s.ea[7:0] = rdata_in;
                end
                nxt_s.addr  = (s_ff.st == ST_OPER2) ? {s_ff.ea[15:8], rdata_in} : s_ff.ea;
                nxt_s.st    = is_store ? ST_WR_HI : ST_RD;
                nxt_s.rw    = !is_store;
                nxt_s.wdata = store_val[15:8];
            end
            ST_WR_HI:
            begin
                nxt_s.addr  = s_ff.addr + 16'h0001;
                nxt_s.wdata = store_val[7:0];
                nxt_s.rw    = 1'b0;
                nxt_s.st    = ST_WR_LO;
            end
            ST_WR_LO:
            begin
                nxt_s.flags[FLAG_N] = store_val[15];
                nxt_s.flags[FLAG_Z] = (store_val == 16'h0000);
                nxt_s.flags[FLAG_V] = 1'b0;
                nxt_s.addr    = s_ff.pc;
                nxt_s.opfetch = 1'b1;
                nxt_s.st      = ST_FETCH;
            end
            ST_RD:
            begin
                if (s_ff.tgt == TGT_B)
                    nxt_s.acc_b = alu_bus.diff;
                else
                    nxt_s.acc_a = alu_bus.diff;
                nxt_s.flags[FLAG_N] = alu_bus.flag_n;
                nxt_s.flags[FLAG_Z] = alu_bus.flag_z;
                nxt_s.flags[FLAG_V] = alu_bus.flag_v;
                nxt_s.flags[FLAG_C] = alu_bus.flag_c;
                nxt_s.addr    = s_ff.pc;
                nxt_s.opfetch = 1'b1;
                nxt_s.st      = ST_FETCH;
            end
            default:
            begin
                nxt_s.addr    = s_ff.pc;
                nxt_s.opfetch = 1'b1;
                nxt_s.st      = ST_FETCH;
            end
        endcase
    end

    // State register with synchronous reset
    always_ff @(posedge core_clk_in)
    begin
        if (reset_in)
            s_ff <= RESET_STATE;
        else
            s_ff <= nxt_s;
    end

    // Outputs straight from the state register
    assign addr_out    = s_ff.addr;
    assign wdata_out   = s_ff.wdata;
    assign rw_out      = s_ff.rw;
    assign opfetch_out = s_ff.opfetch;
    assign acc_a_out   = s_ff.acc_a;
    assign acc_b_out   = s_ff.acc_b;
    assign sp_out      = s_ff.sp;
    assign ix_out      = s_ff.ix;
    assign iy_out      = s_ff.iy;
    assign flags_out   = s_ff.flags;
endmodule // spse_exec
`default_nettype wire

// ---- logic/spse_pkg.sv ----
// Package with opcodes, flag positions, reset values and state types for the store and subtract logic
package spse_pkg;
    // ********************************
    // Opcodes and prebytes
    // ********************************
    localparam logic [7:0] PRE_18       = 8'h18;
    localparam logic [7:0] PRE_1A       = 8'h1a;
    localparam logic [7:0] PRE_CD       = 8'hcd;
    localparam logic [7:0] OP_SP_DIR    = 8'h9f;
    localparam logic [7:0] OP_SP_EXT    = 8'hbf;
    localparam logic [7:0] OP_SP_IND    = 8'haf;
    localparam logic [7:0] OP_XY_DIR    = 8'hdf;
    localparam logic [7:0] OP_XY_EXT    = 8'hff;
    localparam logic [7:0] OP_XY_IND    = 8'hef;
    localparam logic [7:0] OP_SUB_A_IMM = 8'h80;
    localparam logic [7:0] OP_SUB_A_DIR = 8'h90;
    localparam logic [7:0] OP_SUB_A_EXT = 8'hb0;
    localparam logic [7:0] OP_SUB_A_IND = 8'ha0;
    localparam logic [7:0] OP_SUB_B_IMM = 8'hc0;
    localparam logic [7:0] OP_SUB_B_DIR = 8'hd0;
    localparam logic [7:0] OP_SUB_B_EXT = 8'hf0;
    localparam logic [7:0] OP_SUB_B_IND = 8'he0;

    // ********************************
    // Addresses, flags and reset values
    // ********************************
    localparam logic [15:0] IDLE_ADDR   = 16'hffff;
    localparam logic [7:0]  DIRECT_PAGE = 8'h00;
    localparam int          FLAG_N      = 3;
    localparam int          FLAG_Z      = 2;
    localparam int          FLAG_V      = 1;
    localparam int          FLAG_C      = 0;
    localparam logic [7:0]  FLAG_RESET  = 8'h00;
    localparam logic [15:0] PC_RESET    = 16'h0000;
    localparam logic [15:0] REG_RESET   = 16'h0000;

    // ********************************
    // Types
    // ********************************
    typedef enum logic [2:0] {ST_FETCH, ST_OPER1, ST_OPER2, ST_IDLE, ST_WR_HI, ST_WR_LO, ST_RD} spse_state_t;
    typedef enum logic [1:0] {PFX_NONE, PFX_18, PFX_1A, PFX_CD} spse_pfx_t;
    typedef enum logic [2:0] {TGT_SP, TGT_X, TGT_Y, TGT_A, TGT_B} spse_tgt_t;
    typedef enum logic [2:0] {MODE_IMM, MODE_DIR, MODE_EXT, MODE_INDX, MODE_INDY} spse_mode_t;

    typedef struct packed {
        logic       valid;
        spse_tgt_t  tgt;
        spse_mode_t mode;
    } spse_dec_t;
endpackage : spse_pkg

// ---- logic/spse_alu_if.sv ----
// Interface carrying operands and results between the sequencer and the subtract unit
`timescale 1ns/1ps
`default_nettype none
interface spse_alu_if;
    logic [7:0] acc;
    logic [7:0] opnd;
    logic [7:0] diff;
    logic       flag_n;
    logic       flag_z;
    logic       flag_v;
    logic       flag_c;

    modport calc (input acc, input opnd, output diff, output flag_n, output flag_z, output flag_v, output flag_c);
    modport user (output acc, output opnd, input diff, input flag_n, input flag_z, input flag_v, input flag_c);
endinterface : spse_alu_if
`default_nettype wire

// ---- logic/spse_sub_alu.sv ----
// Eight-bit subtract unit with condition flag results
`timescale 1ns/1ps
`default_nettype none
module spse_sub_alu
(
    spse_alu_if.calc alu
);
    logic       x7;
    logic       m7;
    logic       r7;
    logic [7:0] res;

    // Difference and sign bits
    always_comb
    begin
        res = alu.acc - alu.opnd;
        x7  = alu.acc[7];
        m7  = alu.opnd[7];
        r7  = res[7];
    end

    // N, V and C from the sign bits, so no ninth bit is needed
    assign alu.diff   = res;
    assign alu.flag_n = r7;
    assign alu.flag_z = (res == 8'h00);
    assign alu.flag_v = (x7 & ~m7 & ~r7) | (~x7 & m7 & r7);
    assign alu.flag_c = (~x7 & m7) | (m7 & r7) | (r7 & ~x7);
endmodule // spse_sub_alu
`default_nettype wire

// ---- bench/spse_mem_model.sv ----
// Behavioural memory standing on the far side of the sequencer bus
`timescale 1ns/1ps
`default_nettype none
module spse_mem_model
(
    input  wire logic        core_clk_in,
    input  wire logic [15:0] addr_in,
    input  wire logic [7:0]  wdata_in,
    input  wire logic        rw_in,
    output logic [7:0]       rdata_out
);
    logic [7:0] mem [0:65535];

    // Cleared at start so untouched code reads as one-cycle no-ops
    initial
    begin
        for (int i = 0; i < 65536; i++)
            mem[i] = 8'h00;
    end

    // A write lands at the edge that ends the cycle with rw low
    always @(posedge core_clk_in)
        if (!rw_in)
            mem[addr_in] <= wdata_in;

    // No stale byte on write cycles: the inverse shows a missing read/write turn-around
    assign rdata_out = rw_in ? mem[addr_in] : ~wdata_in;
endmodule // spse_mem_model
`default_nettype wire

// ---- bench/spse_exec_monitor.sv ----
// Concurrent checks on the ports of the store and subtract sequencer
`timescale 1ns/1ps
`default_nettype none
module spse_exec_monitor
    import spse_pkg::*;
(
    input wire logic                core_clk_in,
    input wire logic                reset_in,
    input wire logic [7:0]          rdata_in,
    input wire logic                load_en_in,
    input wire spse_pkg::spse_tgt_t load_sel_in,
    input wire logic [15:0]         load_val_in,
    input wire logic [15:0]         addr_out,
    input wire logic [7:0]          wdata_out,
    input wire logic                rw_out,
    input wire logic                opfetch_out,
    input wire logic [7:0]          acc_a_out,
    input wire logic [7:0]          acc_b_out,
    input wire logic [15:0]         sp_out,
    input wire logic [15:0]         ix_out,
    input wire logic [15:0]         iy_out,
    input wire logic [7:0]          flags_out
);
    logic       after_pfx_ff;
    logic [7:0] acc_a_ff;
    logic [7:0] opnd;

    // Prefixed forms reuse plain opcodes, so plain-form checks skip the cycle after a prebyte
    always_ff @(posedge core_clk_in)
        after_pfx_ff <= opfetch_out && (rdata_in == PRE_18 || rdata_in == PRE_1A || rdata_in == PRE_CD);
    always_ff @(posedge core_clk_in)
        acc_a_ff <= acc_a_out;
    assign opnd = acc_a_ff - acc_a_out;

    default clocking @(posedge core_clk_in); endclocking
    default disable iff (reset_in);

    // ********************************
    // Bus sequence and flag checks
    // ********************************
    chk_write_pair_addr: assert property ($fell(rw_out) |=> !rw_out && addr_out == $past(addr_out) + 16'h1)
        else $error("second write byte not at next address");
    chk_write_pair_end: assert property (!rw_out && !$past(rw_out) |=> rw_out)
        else $error("more than two write cycles in a row");
    chk_fetch_is_read: assert property (opfetch_out |-> rw_out)
        else $error("fetch cycle with read/write low");
    chk_write_hi_lo: assert property ($fell(rw_out) |=>
        (wdata_out == sp_out[7:0] && $past(wdata_out) == sp_out[15:8]) ||
        (wdata_out == ix_out[7:0] && $past(wdata_out) == ix_out[15:8]) ||
        (wdata_out == iy_out[7:0] && $past(wdata_out) == iy_out[15:8]))
        else $error("written bytes are not high then low of a register");
    chk_direct_seq: assert property (opfetch_out && !after_pfx_ff && rdata_in == OP_SP_DIR |=>
        (rw_out && addr_out == $past(addr_out) + 16'h1) ##1 (!rw_out && addr_out == {DIRECT_PAGE, $past(rdata_in)})
        ##1 !rw_out ##1 opfetch_out)
        else $error("direct store sequence wrong");
    chk_ext_seq: assert property (opfetch_out && !after_pfx_ff && rdata_in == OP_SP_EXT |=> rw_out ##1 rw_out
        ##1 (!rw_out && addr_out == {$past(rdata_in, 2), $past(rdata_in)}) ##1 !rw_out ##1 opfetch_out)
        else $error("extended store sequence wrong");
    chk_index_idle: assert property (opfetch_out && !after_pfx_ff && rdata_in == OP_SP_IND |=> rw_out
        ##1 (rw_out && addr_out == IDLE_ADDR) ##1 (!rw_out && addr_out == ix_out + {8'h00, $past(rdata_in, 2)})
        ##1 !rw_out ##1 opfetch_out)
        else $error("indexed store sequence wrong");
    chk_upper_flags: assert property ($stable(flags_out[7:4]))
        else $error("upper condition bits changed");
    chk_sub_flags: assert property ($changed(acc_a_out) && !$past(load_en_in) && !$past(reset_in) |->
        flags_out[3:0] == {acc_a_out[7], acc_a_out == 8'h00,
        (acc_a_ff[7] != opnd[7]) && (acc_a_out[7] != acc_a_ff[7]), opnd > acc_a_ff})
        else $error("subtract flags do not match difference");
    chk_store_flags: assert property (!rw_out && !$past(rw_out) |=> flags_out[FLAG_N] == $past(wdata_out[7], 2) &&
        flags_out[FLAG_Z] == ({$past(wdata_out, 2), $past(wdata_out)} == 16'h0000) && !flags_out[FLAG_V] &&
        flags_out[FLAG_C] == $past(flags_out[FLAG_C]))
        else $error("store flags wrong");

    cover property ($fell(rw_out));
    cover property (rw_out && addr_out == IDLE_ADDR && !opfetch_out);
    cover property ($changed(acc_a_out) && !$past(load_en_in));
endmodule // spse_exec_monitor

bind spse_exec spse_exec_monitor i_mon (.core_clk_in(core_clk_in), .reset_in(reset_in), .rdata_in(rdata_in),
    .load_en_in(load_en_in), .load_sel_in(load_sel_in), .load_val_in(load_val_in), .addr_out(addr_out),
    .wdata_out(wdata_out), .rw_out(rw_out), .opfetch_out(opfetch_out), .acc_a_out(acc_a_out),
    .acc_b_out(acc_b_out), .sp_out(sp_out), .ix_out(ix_out), .iy_out(iy_out), .flags_out(flags_out));
`default_nettype wire

// ---- bench/store_pair_and_subtract_exec_test.sv ----
// Self-checking bench for the store and subtract sequencer
`timescale 1ns/1ps
`default_nettype none
module store_pair_and_subtract_exec_test;
    import spse_pkg::*;
    logic        core_clk_in;
    logic        reset_in;
    logic [7:0]  rdata;
    logic        load_en_in;
    spse_tgt_t   load_sel_in;
    logic [15:0] load_val_in;
    logic [15:0] addr_out;
    logic [7:0]  wdata_out;
    logic        rw_out;
    logic        opfetch_out;
    logic [7:0]  acc_a_out;
    logic [7:0]  acc_b_out;
    logic [15:0] sp_out;
    logic [15:0] ix_out;
    logic [15:0] iy_out;
    logic [7:0]  flags_out;
    logic [15:0] r_sp, r_x, r_y;
    logic [7:0]  r_a, r_b;
    int          err_total;
    int          cmp_count;

    spse_exec i_dut (.core_clk_in(core_clk_in), .reset_in(reset_in), .rdata_in(rdata), .load_en_in(load_en_in),
        .load_sel_in(load_sel_in), .load_val_in(load_val_in), .addr_out(addr_out), .wdata_out(wdata_out),
        .rw_out(rw_out), .opfetch_out(opfetch_out), .acc_a_out(acc_a_out), .acc_b_out(acc_b_out),
        .sp_out(sp_out), .ix_out(ix_out), .iy_out(iy_out), .flags_out(flags_out));
    spse_mem_model i_mem (.core_clk_in(core_clk_in), .addr_in(addr_out), .wdata_in(wdata_out), .rw_in(rw_out),
        .rdata_out(rdata));

    // 40 MHz clock
    initial
    begin
        core_clk_in = 1'b0;
        forever #12.5 core_clk_in = ~core_clk_in;
    end

    // ********************************
    // Shared tasks
    // ********************************
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic load(input spse_tgt_t sel, input logic [15:0] val);
        @(posedge core_clk_in);
        load_en_in <= 1'b1;
        load_sel_in <= sel;
        load_val_in <= val;
    endtask

    // Short reset, then registers loaded while the core runs no-ops below the program
    task automatic boot();
        @(posedge core_clk_in);
        reset_in <= 1'b1;
        @(posedge core_clk_in);
        reset_in <= 1'b0;
        load(TGT_SP, r_sp);
        load(TGT_X, r_x);
        load(TGT_Y, r_y);
        load(TGT_A, {8'h00, r_a});
        load(TGT_B, {8'h00, r_b});
        @(posedge core_clk_in);
        load_en_in <= 1'b0;
    endtask

    // Program sits at 0010 with a no-op after it; counts cycles from its fetch to the next
    task automatic run(input logic [31:0] prog, input int len, output int cyc);
        int k;
        for (k = 0; k < 4; k++)
            i_mem.mem[16'h0010 + k] = prog[31 - 8 * k -: 8];
        i_mem.mem[16'h0010 + len] = 8'h00;
        boot();
        cyc = -99;
        for (k = 0; k < 40 && cyc < 0; k++)
        begin
            @(posedge core_clk_in);
            #1;
            if (opfetch_out === 1'b1 && addr_out === 16'h0010)
                cyc = 0;
        end
        for (k = 0; k < 20; k++)
        begin
            @(posedge core_clk_in);
            #1;
            cyc++;
            if (opfetch_out === 1'b1 && addr_out === 16'h0010 + len[15:0])
                break;
        end
    endtask

    task automatic do_store(input logic [31:0] prog, input int len, input logic [15:0] ea, val, input int cyc_exp);
        int cyc;
        i_mem.mem[ea] = ~val[15:8];
        i_mem.mem[ea + 16'h1] = ~val[7:0];
        run(prog, len, cyc);
        check("store cycles", cyc[15:0], cyc_exp[15:0]);
        check("high byte", {8'h00, i_mem.mem[ea]}, {8'h00, val[15:8]});
        check("low byte", {8'h00, i_mem.mem[ea + 16'h1]}, {8'h00, val[7:0]});
        check("store flags", {13'h0000, flags_out[3:1]}, {13'h0000, val[15], val == 16'h0000, 1'b0});
    endtask

    task automatic do_sub(input logic [31:0] prog, input int len, input logic isb, input logic [7:0] x, m);
        int         cyc;
        logic [7:0] r;
        r = x - m;
        run(prog, len, cyc);
        check("difference", {8'h00, isb ? acc_b_out : acc_a_out}, {8'h00, r});
        check("other acc", {8'h00, isb ? acc_a_out : acc_b_out}, {8'h00, x});
        check("sub flags", {8'h00, flags_out}, {12'h000, r[7], r == 8'h00,
            (x[7] != m[7]) && (r[7] != x[7]), m > x});
    endtask

    // ********************************
    // Scenarios
    // ********************************
    task automatic t_store_sp();
        do_store(32'h9f800000, 2, 16'h0080, r_sp, 4);
        do_store(32'hbf123400, 3, 16'h1234, r_sp, 5);
        do_store(32'hafa00000, 2, 16'h0020, r_sp, 5);
        do_store(32'h18af0500, 3, 16'h0045, r_sp, 6);
    endtask

    task automatic t_store_x();
        do_store(32'hdf820000, 2, 16'h0082, r_x, 4);
        do_store(32'hff123600, 3, 16'h1236, r_x, 5);
        do_store(32'hefa40000, 2, 16'h0024, r_x, 5);
        do_store(32'hcdef0800, 3, 16'h0048, r_x, 6);
    endtask

    task automatic t_store_y();
        do_store(32'h18df8400, 3, 16'h0084, r_y, 5);
        do_store(32'h18ff1238, 4, 16'h1238, r_y, 6);
        do_store(32'h1aefa800, 3, 16'h0028, r_y, 6);
        do_store(32'h18ef0c00, 3, 16'h004c, r_y, 6);
        r_y = 16'h0000;
        do_store(32'h18df8600, 3, 16'h0086, r_y, 5);
        r_y = 16'h0040;
    endtask

    // Borrow, signed overflow and zero cases in every addressing form
    task automatic t_sub();
        logic [23:0] xs;
        logic [23:0] ms;
        logic [7:0]  x;
        logic [7:0]  m;
        xs = 24'h508033;
        ms = 24'h700133;
        for (int i = 0; i < 3; i++)
        begin
            x = xs[23 - 8 * i -: 8];
            m = ms[23 - 8 * i -: 8];
            r_a = x;
            r_b = x;
            i_mem.mem[16'h0090] = m;
            i_mem.mem[16'h0045] = m;
            i_mem.mem[16'hff90] = m;
            do_sub({8'h80, m, 16'h0000}, 2, 1'b0, x, m);
            do_sub(32'h90900000, 2, 1'b0, x, m);
            do_sub(32'hf0009000, 3, 1'b1, x, m);
            do_sub(32'he0100000, 2, 1'b1, x, m);
            do_sub(32'h18a00500, 3, 1'b0, x, m);
            // Same forms on the other accumulator, so every decoded subtract code runs
            do_sub({8'hc0, m, 16'h0000}, 2, 1'b1, x, m);
            do_sub(32'hd0900000, 2, 1'b1, x, m);
            do_sub(32'hb0009000, 3, 1'b0, x, m);
            do_sub(32'ha0100000, 2, 1'b0, x, m);
            do_sub(32'h18e00500, 3, 1'b1, x, m);
        end
    endtask

    task automatic results();
        if (err_total == 0 && cmp_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // Main sequence
    initial
    begin
        reset_in = 1'b1;
        load_en_in = 1'b0;
        load_sel_in = TGT_SP;
        load_val_in = 16'h0000;
        err_total = 0;
        cmp_count = 0;
        r_sp = 16'h8abc;
        r_x = 16'hff80;
        r_y = 16'h0040;
        r_a = 8'h00;
        r_b = 8'h00;
        repeat (16) @(posedge core_clk_in);
        t_store_sp();
        t_store_x();
        t_store_y();
        t_sub();
        results();
    end

    // Whole run needs about 1000 cycles; a hang is cut off well beyond that
    initial
    begin
        repeat (5000) @(posedge core_clk_in);
        err_total++;
        results();
    end
endmodule // store_pair_and_subtract_exec_test
`default_nettype wire
